// File: common/tmb_pkg.sv
package tmb_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] TMB_IDX_MODE = 16'hffb0;
  localparam logic [15:0] TMB_IDX_COUNT = 16'hffb1;
  localparam logic [15:0] TMB_IDX_IRQ = 16'hffb2;

  // Reset values and counter top value
  localparam logic [7:0] TMB_MODE_RST = 8'h10;
  localparam logic [7:0] TMB_COUNT_RST = 8'h00;
  localparam logic [7:0] TMB_COUNT_TOP = 8'hff;

  // Mode register fields
  localparam int TMB_RSV_BIT = 4;
  localparam logic [7:0] TMB_RSV_MASK = 8'h10;
  localparam int TMB_OSEL_SUB = 7;
  localparam int TMB_OSEL_HI = 6;
  localparam int TMB_OSEL_LO = 5;
  localparam int TMB_CSEL_TB = 3;
  localparam int TMB_CSEL_CLR = 2;
  localparam int TMB_CSEL_HI = 2;

  // Interrupt register fields
  localparam int TMB_IRQ_FLAG = 0;
  localparam int TMB_IRQ_EN = 1;

  // Prescaler widths and tap depths (log2 of the divide ratio)
  localparam int TMB_PSS_W = 13;
  localparam int TMB_PSW_W = 7;
  localparam int TMB_SYS_LOG [8] = '{13, 12, 11, 9, 8, 7, 5, 3};
  localparam int TMB_SUB_LOG [4] = '{7, 6, 5, 2};
  // Bit that squares at divide by 32 on either prescaler
  localparam int TMB_SQ_TOP = 4;

  // Chip operating mode supplied by the system controller
  typedef enum logic [2:0] {
    TMB_OP_ACTIVE = 3'h0,
    TMB_OP_SLEEP = 3'h1,
    TMB_OP_WATCH = 3'h2,
    TMB_OP_SUBACTIVE = 3'h3,
    TMB_OP_SUBSLEEP = 3'h4,
    TMB_OP_STANDBY = 3'h5
  } tmb_opmode_t;

endpackage : tmb_pkg

// File: common/tmb_tap_if.sv
`timescale 1ns/10ps
// Prescaler taps passed from the prescaler to the timer core
interface tmb_tap_if;
  logic [7:0] sys_tap;
  logic [3:0] sub_tap;
  logic [3:0] sys_sq;
  logic [3:0] sub_sq;
  logic psw_clr;

  modport pre (
    input psw_clr,
    output sys_tap,
    output sub_tap,
    output sys_sq,
    output sub_sq
  );

  modport core (
    output psw_clr,
    input sys_tap,
    input sub_tap,
    input sys_sq,
    input sub_sq
  );
endinterface : tmb_tap_if

// File: design/tmb_prescale.sv
`timescale 1ns/10ps
// System and sub-clock prescalers; taps are one-cycle enables
module tmb_prescale
  import tmb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sub_clk_i,
  tmb_tap_if.pre tap
);

  logic [TMB_PSS_W-1:0] pss_q;
  logic [TMB_PSS_W-1:0] pss_d;
  logic [TMB_PSW_W-1:0] psw_q;
  logic [TMB_PSW_W-1:0] psw_d;
  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic sub_edge;

  // Sub-clock rising edge, seen only after two synchroniser stages
  assign sub_edge = sync_q[1] & ~sync_q[2];

  // Next state of both prescalers
  always_comb begin
    sync_d = {sync_q[1:0], sub_clk_i};
    pss_d = pss_q + {{(TMB_PSS_W-1){1'b0}}, 1'b1};
    psw_d = psw_q;
    if (tap.psw_clr) begin
      psw_d = '0;
    end else if (sub_edge) begin
      psw_d = psw_q + {{(TMB_PSW_W-1){1'b0}}, 1'b1};
    end
  end

  // Register stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pss_q <= '0;
      psw_q <= '0;
      sync_q <= '0;
    end else begin
      pss_q <= pss_d;
      psw_q <= psw_d;
      sync_q <= sync_d;
    end
  end

  // Taps fire when the low bits roll over, never from a select change
  for (genvar i = 0; i < 8; i++) begin : g_sys
    assign tap.sys_tap[i] = &pss_q[TMB_SYS_LOG[i]-1:0];
  end
  for (genvar j = 0; j < 4; j++) begin : g_sub
    assign tap.sub_tap[j] = sub_edge & ~tap.psw_clr &
                            (&psw_q[TMB_SUB_LOG[j]-1:0]);
    assign tap.sys_sq[j] = pss_q[TMB_SQ_TOP-j];
    assign tap.sub_sq[j] = psw_q[TMB_SQ_TOP-j];
  end

  property p_tap_space;
    @(posedge clk_i) disable iff (rst_i)
      tap.sys_tap[7] |=> !tap.sys_tap[7] [*7];
  endproperty
  a_tap_space: assert property (p_tap_space)
    else $error("divide-by-8 tap fired early");

endmodule : tmb_prescale

// File: design/tmb_timer.sv
// Our own choice: the Wishbone slave port.
`timescale 1ns/10ps
// Functional notes
// - Eight-bit timer works as interval timer or as clock time base.
// - Output select picks system or sub clock divided by 32,16,8,4.
// - System-derived output only in active/sleep; sub-derived adds subactive.
// - Mode register bit 4 always reads one; writes cannot change it.
// - Interval clock select 0 to 7 picks system taps 8192 down to 8.
// - Time-base select gives overflow every 1, 0.5, 0.25, 0.03125 s.
// - Both upper select bits set holds sub prescaler and counter reset.
// - Mode register resets to 10 hex: divide-32 output, 8192 interval.
// - Every counter overflow raises an interrupt request.
// - Count is read-only up-counter, resets to zero, unreadable in subactive.
// - From FF next clock wraps to zero and sets flag; enable gates irq.
// - Interval runs only active/sleep; time base runs except standby.
module tmb_timer
  import tmb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [17:2] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire tmb_opmode_t op_mode_i,
  input wire logic sub_clk_i,
  output logic divided_clock_out_pin_o,
  output logic irq_o
);

  tmb_tap_if taps ();

  // Prescalers live in their own module
  tmb_prescale u_pre (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sub_clk_i(sub_clk_i),
    .tap(taps.pre)
  );

  logic ack_q;
  logic ack_d;
  logic [31:0] dat_q;
  logic [31:0] dat_d;
  logic [7:0] timer_mode_select_q;
  logic [7:0] timer_mode_select_d;
  logic [7:0] timer_count_value_q;
  logic [7:0] timer_count_value_d;
  logic overflow_request_flag_q;
  logic overflow_request_flag_d;
  logic overflow_irq_enable_q;
  logic overflow_irq_enable_d;
  logic irq_q;
  logic irq_d;
  logic clk_out_q;
  logic clk_out_d;

  logic bus_hit;
  logic wr_en;
  logic sys_mode;
  logic sub_mode;
  logic hold;
  logic iv_run;
  logic tb_run;
  logic cnt_en;
  logic [2:0] osel;

  // Mode decode from the system controller
  assign sys_mode = (op_mode_i == TMB_OP_ACTIVE) ||
                    (op_mode_i == TMB_OP_SLEEP);
  assign sub_mode = sys_mode || (op_mode_i == TMB_OP_SUBACTIVE);

  // Bus request; writes commit at the edge that shows ack to the master
  assign bus_hit = wb_cyc_i & wb_stb_i;
  assign wr_en = bus_hit & wb_we_i & ack_q & wb_sel_i[0];

  // Counter source and gating
  assign hold = timer_mode_select_q[TMB_CSEL_TB] &
                timer_mode_select_q[TMB_CSEL_CLR];
  assign iv_run = ~timer_mode_select_q[TMB_CSEL_TB] & sys_mode;
  assign tb_run = timer_mode_select_q[TMB_CSEL_TB] & ~hold &
                  (op_mode_i != TMB_OP_STANDBY);
  // A tap is a pulse, so a select change alone never counts
  always_comb begin
    cnt_en = 1'b0;
    if (iv_run) begin
      cnt_en = taps.sys_tap[timer_mode_select_q[TMB_CSEL_HI:0]];
    end else if (tb_run) begin
      cnt_en = taps.sub_tap[timer_mode_select_q[1:0]];
    end
  end
  assign taps.psw_clr = hold;

  // Wishbone answer: ack one cycle after the request, dropped next cycle
  always_comb begin
    ack_d = bus_hit & ~ack_q;
    dat_d = dat_q;
    if (bus_hit & ~ack_q & ~wb_we_i) begin
      case (wb_adr_i)
        TMB_IDX_MODE: begin
          dat_d = {24'h000000, timer_mode_select_q};
        end
        TMB_IDX_COUNT: begin
          // Count is hidden in subactive mode; reads give zero there
          if (op_mode_i == TMB_OP_SUBACTIVE) begin
            dat_d = 32'h00000000;
          end else begin
            dat_d = {24'h000000, timer_count_value_q};
          end
        end
        TMB_IDX_IRQ: begin
          dat_d = {30'h0, overflow_irq_enable_q,
                   overflow_request_flag_q};
        end
        default: begin
          dat_d = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  // Mode register; the reserved bit is forced on every write
  always_comb begin
    timer_mode_select_d = timer_mode_select_q;
    if (wr_en && (wb_adr_i == TMB_IDX_MODE)) begin
      timer_mode_select_d = wb_dat_i[7:0] | TMB_RSV_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_mode_select_q <= TMB_MODE_RST;
    end else begin
      timer_mode_select_q <= timer_mode_select_d;
    end
  end

  // Counter, overflow flag and enable; hardware set beats software clear
  always_comb begin
    timer_count_value_d = timer_count_value_q;
    overflow_request_flag_d = overflow_request_flag_q;
    overflow_irq_enable_d = overflow_irq_enable_q;
    if (wr_en && (wb_adr_i == TMB_IDX_IRQ)) begin
      overflow_irq_enable_d = wb_dat_i[TMB_IRQ_EN];
      if (!wb_dat_i[TMB_IRQ_FLAG]) begin
        overflow_request_flag_d = 1'b0;
      end
    end
    if (hold) begin
      timer_count_value_d = TMB_COUNT_RST;
    end else if (cnt_en) begin
      timer_count_value_d = 8'(timer_count_value_q + 8'h01);
      if (timer_count_value_q == TMB_COUNT_TOP) begin
        overflow_request_flag_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_count_value_q <= TMB_COUNT_RST;
      overflow_request_flag_q <= 1'b0;
      overflow_irq_enable_q <= 1'b0;
    end else begin
      timer_count_value_q <= timer_count_value_d;
      overflow_request_flag_q <= overflow_request_flag_d;
      overflow_irq_enable_q <= overflow_irq_enable_d;
    end
  end

  // Interrupt line and clock output, both registered
  assign osel = timer_mode_select_q[TMB_OSEL_SUB:TMB_OSEL_LO];
  always_comb begin
    irq_d = overflow_request_flag_q & overflow_irq_enable_q;
    clk_out_d = 1'b0;
    if (!osel[2]) begin
      clk_out_d = sys_mode & taps.sys_sq[osel[1:0]];
    end else begin
      clk_out_d = sub_mode & taps.sub_sq[osel[1:0]];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
      clk_out_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
      clk_out_q <= clk_out_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign irq_o = irq_q;
  assign divided_clock_out_pin_o = clk_out_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Checks
  property p_mode_rst;
    @(posedge clk_i) disable iff (1'b0)
      rst_i |=> (timer_mode_select_q == TMB_MODE_RST);
  endproperty
  a_mode_rst: assert property (p_mode_rst)
    else $error("mode register not 10 hex after reset");

  property p_rsv_bit;
    timer_mode_select_q[TMB_RSV_BIT];
  endproperty
  a_rsv_bit: assert property (p_rsv_bit)
    else $error("reserved mode bit reads zero");

  property p_hold;
    hold |-> !cnt_en ##1 (timer_count_value_q == TMB_COUNT_RST);
  endproperty
  a_hold: assert property (p_hold)
    else $error("counter not held while cleared");

  property p_wrap;
    (cnt_en && !hold && timer_count_value_q == TMB_COUNT_TOP) |=>
      (timer_count_value_q == TMB_COUNT_RST) && overflow_request_flag_q;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("overflow did not wrap and flag");

  property p_inc;
    (cnt_en && !hold && timer_count_value_q != TMB_COUNT_TOP) |=>
      timer_count_value_q == 8'($past(timer_count_value_q) + 8'h01);
  endproperty
  a_inc: assert property (p_inc)
    else $error("counter did not step by one");

  property p_iv_halt;
    (!timer_mode_select_q[TMB_CSEL_TB] && !sys_mode) |-> !cnt_en;
  endproperty
  a_iv_halt: assert property (p_iv_halt)
    else $error("interval count outside active or sleep");

  property p_no_spur;
    (!cnt_en && !hold) |=> $stable(timer_count_value_q);
  endproperty
  a_no_spur: assert property (p_no_spur)
    else $error("counter moved without a tap");

  property p_irq;
    (overflow_request_flag_q && overflow_irq_enable_q) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("enabled overflow gave no interrupt");

  property p_clk_gate;
    (!osel[2] && !sys_mode) ##1 (!osel[2] && !sys_mode) |=>
      !divided_clock_out_pin_o;
  endproperty
  a_clk_gate: assert property (p_clk_gate)
    else $error("system clock output outside active or sleep");

  // Mode gating, hidden reads and output shape
  property p_osel_sub_gate;
    (osel[2] && !sub_mode) |=> !divided_clock_out_pin_o;
  endproperty
  a_osel_sub_gate: assert property (p_osel_sub_gate)
    else $error("sub clock output outside its modes");

  property p_clk_div4;
    (osel == 3'h3 && sys_mode) [*3] |=>
      divided_clock_out_pin_o != $past(divided_clock_out_pin_o, 2);
  endproperty
  a_clk_div4: assert property (p_clk_div4)
    else $error("divide-by-4 output did not toggle every two cycles");

  property p_sub_hidden;
    (bus_hit && !ack_q && !wb_we_i && (wb_adr_i == TMB_IDX_COUNT) &&
     (op_mode_i == TMB_OP_SUBACTIVE)) |=> (wb_dat_o == 32'h00000000);
  endproperty
  a_sub_hidden: assert property (p_sub_hidden)
    else $error("count visible in subactive mode");

  property p_tb_standby;
    (timer_mode_select_q[TMB_CSEL_TB] && (op_mode_i == TMB_OP_STANDBY))
      |-> !cnt_en;
  endproperty
  a_tb_standby: assert property (p_tb_standby)
    else $error("time base counted in standby");

  property p_irq_off;
    !(overflow_request_flag_q && overflow_irq_enable_q) |=> !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt without enabled overflow flag");

endmodule : tmb_timer

// File: dv/tb.sv
`timescale 1ns/10ps
module tb;
  import tmb_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic sub_clk = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, dat_o;
  logic ack, pin, irq;
  logic [7:0] r;
  tmb_opmode_t op = TMB_OP_ACTIVE;
  int fails = 0, samples_checked = 0, mode_m, e, exp_q[$];

  tmb_timer dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .op_mode_i(op),
    .sub_clk_i(sub_clk), .divided_clock_out_pin_o(pin), .irq_o(irq));

  // 20 MHz system clock and a free-running 32.768 kHz sub-clock
  initial forever #25 clk_i = ~clk_i;
  initial forever #15259 sub_clk = ~sub_clk;

  task close_out;
    $display("compares %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  task chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk

  // Classic cycle; request held until the edge that samples ack high
  task wb(input logic w, input logic [15:0] a, input logic [7:0] d,
          input logic [3:0] s, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= {24'h000000, d};
    // Ack and data are read at the edge, before it updates them
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk(n < 20, "no ack");
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task rd(input logic [15:0] a, input logic [7:0] x, input string m);
    wb(1'b0, a, 8'h00, 4'h1, r);
    chk(r === x, m);
  endtask : rd

  task wr(input logic [15:0] a, input logic [7:0] d);
    wb(1'b1, a, d, 4'h1, r);
  endtask : wr

  // Count advance over a wait, with slack for prescaler phase
  task span(input int w, input int lo, input int hi, input string m);
    logic [7:0] c0, d;
    wb(1'b0, TMB_IDX_COUNT, 8'h00, 4'h1, c0);
    repeat (w) @(posedge clk_i);
    wb(1'b0, TMB_IDX_COUNT, 8'h00, 4'h1, r);
    d = r - c0;
    chk(!$isunknown(d) && d >= lo && d <= hi, m);
  endtask : span

  // Rising edges on the clock output pin over a number of cycles
  task edges(input int w);
    logic p;
    e = 0;
    p = pin;
    repeat (w) begin
      @(posedge clk_i);
      #1 if (pin === 1'b1 && p === 1'b0) e++;
      p = pin;
    end
  endtask : edges

  initial begin
    void'($urandom(27306));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(TMB_IDX_MODE, 8'h10, "mode reset");
    rd(TMB_IDX_COUNT, 8'h00, "count reset");
    rd(16'h0000, 8'h00, "unmapped read");
    $display("test reset done");
    // Random mode values; reserved bit always reads one
    for (int i = 0; i < 8; i++) begin
      mode_m = $urandom & 8'hef;
      exp_q.push_back(mode_m | 8'h10);
      wr(TMB_IDX_MODE, mode_m[7:0]);
      rd(TMB_IDX_MODE, 8'(exp_q.pop_front()), "mode readback");
    end
    wb(1'b1, TMB_IDX_MODE, 8'h00, 4'h0, r);
    rd(TMB_IDX_MODE, mode_m[7:0] | 8'h10, "sel0 write kept out");
    wr(TMB_IDX_COUNT, 8'h55);
    rd(TMB_IDX_MODE, mode_m[7:0] | 8'h10, "count write");
    $display("test mode register done");
    // Every interval tap: three ticks expected per wait
    for (int c = 0; c < 8; c++) begin
      wr(TMB_IDX_MODE, c[7:0]);
      span(3 << TMB_SYS_LOG[c], 2, 4, "interval rate");
    end
    op <= TMB_OP_WATCH;
    span(64, 0, 0, "interval halts in watch");
    $display("test interval done");
    wr(TMB_IDX_MODE, 8'h0b);
    span(7324, 2, 4, "time base runs in watch");
    wr(TMB_IDX_MODE, 8'h0e);
    span(3000, 0, 0, "select 11 holds count");
    rd(TMB_IDX_COUNT, 8'h00, "count cleared");
    op <= TMB_OP_SUBACTIVE;
    wr(TMB_IDX_MODE, 8'h0b);
    repeat (5000) @(posedge clk_i);
    rd(TMB_IDX_COUNT, 8'h00, "count hidden in subactive");
    $display("test time base done");
    // Overflow from the divide-8 tap with the enable set
    op <= TMB_OP_ACTIVE;
    wr(TMB_IDX_MODE, 8'h07);
    wr(TMB_IDX_IRQ, 8'h02);
    e = 0;
    while (irq !== 1'b1 && e < 3000) begin
      @(posedge clk_i);
      #1 e++;
    end
    chk(e < 3000, "no overflow irq");
    rd(TMB_IDX_IRQ, 8'h03, "flag set");
    wb(1'b0, TMB_IDX_COUNT, 8'h00, 4'h1, r);
    chk(r < 8'h02, "count wrapped");
    wr(TMB_IDX_IRQ, 8'h02);
    repeat (2) @(posedge clk_i);
    #1 chk(irq === 1'b0, "irq cleared");
    rd(TMB_IDX_IRQ, 8'h02, "flag cleared");
    $display("test overflow done");
    // Output clock choices and mode gating
    for (int k = 0; k < 4; k++) begin
      wr(TMB_IDX_MODE, 8'(k * 32 + 7));
      edges(64);
      chk(e >= (2 << k) - 1 && e <= (2 << k) + 1, "clk out");
    end
    op <= TMB_OP_WATCH;
    wr(TMB_IDX_MODE, 8'h67);
    edges(64);
    chk(e == 0, "system out off in watch");
    op <= TMB_OP_SUBACTIVE;
    wr(TMB_IDX_MODE, 8'he7);
    edges(5000);
    chk(e >= 1 && e <= 3, "sub/4 out in subactive");
    op <= TMB_OP_STANDBY;
    wr(TMB_IDX_MODE, 8'heb);
    edges(3000);
    chk(e == 0, "sub out off in standby");
    $display("test clock out done");
    close_out();
  end

  // Hang guard, well past the expected run length
  initial begin
    repeat (90000) @(posedge clk_i);
    fails++;
    close_out();
  end
endmodule : tb
